// file: design/ebio_defines.vh
// Contract
// - one port of eight two-way pins, 0 to 7, each configured on its own
// - per pin, a segment-select bit hands the pin to the segment driver
// - output direction offers high impedance, P open drain, N open drain, CMOS
// - input direction offers high impedance, pull-down or pull-up
// - pin data register at F270 drives each output-direction pin
// - output-direction pins read back the last written data value
// - input-direction pins read back the sampled pin level
// - data bit 0 is low level, 1 is high level
// - direction bit 0 means output (reset), 1 means input
// - direction register at F271, bit n steers pin n
// - all four registers are 8-bit read/write and reset to 00
// - F272 takes byte or word access covering both; F273 byte only
// - drive-mode low holds mode bit 0, drive-mode high mode bit 1, per pin
// - mode code decode: out 00 Z,01 P,10 N,11 CMOS; in 00 Z,01 PD,10 PU,11 Z
`ifndef EBIO_DEFINES_VH
`define EBIO_DEFINES_VH

`define EBIO_PINS 8
`define EBIO_ADDR_W 16
`define EBIO_BUS_W 16

`define EBIO_ADDR_PIN_DATA 16'hF270
`define EBIO_ADDR_PIN_DIRECTION 16'hF271
`define EBIO_ADDR_DRIVE_MODE_LOW 16'hF272
`define EBIO_ADDR_DRIVE_MODE_HIGH 16'hF273
`define EBIO_ADDR_DRIVE_MODE_WORD 16'hF272

`define EBIO_RST_PIN_DATA 8'h00
`define EBIO_RST_PIN_DIRECTION 8'h00
`define EBIO_RST_DRIVE_MODE_LOW 8'h00
`define EBIO_RST_DRIVE_MODE_HIGH 8'h00

`define EBIO_DIR_OUTPUT 1'b0
`define EBIO_DIR_INPUT 1'b1

`define EBIO_MODE_OUT_HIZ 2'h0
`define EBIO_MODE_OUT_PCH 2'h1
`define EBIO_MODE_OUT_NCH 2'h2
`define EBIO_MODE_OUT_CMOS 2'h3
`define EBIO_MODE_IN_HIZ 2'h0
`define EBIO_MODE_IN_PDOWN 2'h1
`define EBIO_MODE_IN_PUP 2'h2
`define EBIO_MODE_IN_HIZ2 2'h3

`define EBIO_SEL_PIN_DATA 4'h1
`define EBIO_SEL_PIN_DIRECTION 4'h2
`define EBIO_SEL_DRIVE_MODE_LOW 4'h4
`define EBIO_SEL_DRIVE_MODE_HIGH 4'h8
`define EBIO_SEL_NONE 4'h0

`endif

// file: design/ebio_addr_decode.v
`include "ebio_defines.vh"

module ebio_addr_decode (
  input wire [15:0] addr,
  input wire word,
  output reg [3:0] byte_sel,
  output reg word_hit
);

  // one-hot register select; a word only lands on the drive-mode pair
  always @* begin
    byte_sel = `EBIO_SEL_NONE;
    word_hit = 1'b0;
    if (word) begin
      word_hit = (addr == `EBIO_ADDR_DRIVE_MODE_WORD);
    end else begin
      case (addr)
        `EBIO_ADDR_PIN_DATA: byte_sel = `EBIO_SEL_PIN_DATA;
        `EBIO_ADDR_PIN_DIRECTION: byte_sel = `EBIO_SEL_PIN_DIRECTION;
        `EBIO_ADDR_DRIVE_MODE_LOW: byte_sel = `EBIO_SEL_DRIVE_MODE_LOW;
        `EBIO_ADDR_DRIVE_MODE_HIGH: byte_sel = `EBIO_SEL_DRIVE_MODE_HIGH;
        default: byte_sel = `EBIO_SEL_NONE;
      endcase
    end
  end

endmodule // ebio_addr_decode

// file: design/ebio_pin_cell.v
`include "ebio_defines.vh"

module ebio_pin_cell (
  input wire dir,
  input wire [1:0] mode,
  input wire level,
  input wire seg_sel,
  input wire seg_level,
  output reg pad_out,
  output reg pad_oe,
  output reg pull_up,
  output reg pull_down
);

  // drive and pull decode for one pin; pulls only ever act on inputs
  always @* begin
    pad_out = 1'b0;
    pad_oe = 1'b0;
    pull_up = 1'b0;
    pull_down = 1'b0;
    if (seg_sel) begin
      // segment driver owns the pad outright
      pad_out = seg_level;
      pad_oe = 1'b1;
    end else if (dir == `EBIO_DIR_OUTPUT) begin
      case (mode)
        `EBIO_MODE_OUT_HIZ: begin
          pad_out = 1'b0;
          pad_oe = 1'b0;
        end
        `EBIO_MODE_OUT_PCH: begin
          // p-channel can only source a high
          pad_out = 1'b1;
          pad_oe = level;
        end
        `EBIO_MODE_OUT_NCH: begin
          // n-channel can only sink a low
          pad_out = 1'b0;
          pad_oe = ~level;
        end
        `EBIO_MODE_OUT_CMOS: begin
          pad_out = level;
          pad_oe = 1'b1;
        end
        default: begin
          pad_out = 1'b0;
          pad_oe = 1'b0;
        end
      endcase
    end else begin
      case (mode)
        `EBIO_MODE_IN_PDOWN: pull_down = 1'b1;
        `EBIO_MODE_IN_PUP: pull_up = 1'b1;
        default: begin
          pull_up = 1'b0;
          pull_down = 1'b0;
        end
      endcase
    end
  end

endmodule // ebio_pin_cell

// file: design/ebio_port.v
`include "ebio_defines.vh"

module ebio_port (
  input wire core_clk,
  input wire rst,
  input wire [15:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire bus_word,
  output reg [15:0] bus_rdata,
  input wire [7:0] pin_in,
  output wire [7:0] pin_out,
  output wire [7:0] pin_oe,
  output wire [7:0] pull_up_en,
  output wire [7:0] pull_down_en,
  input wire [7:0] segment_select,
  input wire [7:0] segment_level
);

  reg [7:0] pin_data;
  reg [7:0] pin_direction;
  reg [7:0] drive_mode_low;
  reg [7:0] drive_mode_high;
  reg [15:0] next_rdata;
  wire [3:0] byte_sel;
  wire word_hit;
  wire [7:0] pin_view;

  // readback merge: written value on outputs, live pad level on inputs
  function [7:0] ebio_merge;
    input [7:0] dir;
    input [7:0] stored;
    input [7:0] pads;
    begin
      ebio_merge = (dir & pads) | (~dir & stored);
    end
  endfunction

  ebio_addr_decode u_decode (
    .addr(bus_addr),
    .word(bus_word),
    .byte_sel(byte_sel),
    .word_hit(word_hit)
  );

  // pin inputs are synchronous, so a read takes them straight into rdata
  assign pin_view = ebio_merge(pin_direction, pin_data, pin_in);

  // register writes; a word at F272 loads both drive-mode bytes at once
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_data <= `EBIO_RST_PIN_DATA;
      pin_direction <= `EBIO_RST_PIN_DIRECTION;
      drive_mode_low <= `EBIO_RST_DRIVE_MODE_LOW;
      drive_mode_high <= `EBIO_RST_DRIVE_MODE_HIGH;
    end else if (bus_wr) begin
      if (byte_sel == `EBIO_SEL_PIN_DATA) begin
        pin_data <= bus_wdata[7:0];
      end
      if (byte_sel == `EBIO_SEL_PIN_DIRECTION) begin
        pin_direction <= bus_wdata[7:0];
      end
      if (byte_sel == `EBIO_SEL_DRIVE_MODE_LOW || word_hit) begin
        drive_mode_low <= bus_wdata[7:0];
      end
      if (byte_sel == `EBIO_SEL_DRIVE_MODE_HIGH) begin
        drive_mode_high <= bus_wdata[7:0];
      end else if (word_hit) begin
        drive_mode_high <= bus_wdata[15:8];
      end
    end
  end

  // read mux; unmapped addresses and stray word accesses answer zero
  always @* begin
    next_rdata = 16'h0000;
    if (word_hit) begin
      next_rdata = {drive_mode_high, drive_mode_low};
    end else begin
      case (byte_sel)
        `EBIO_SEL_PIN_DATA: next_rdata = {8'h00, pin_view};
        `EBIO_SEL_PIN_DIRECTION: next_rdata = {8'h00, pin_direction};
        `EBIO_SEL_DRIVE_MODE_LOW: next_rdata = {8'h00, drive_mode_low};
        `EBIO_SEL_DRIVE_MODE_HIGH: next_rdata = {8'h00, drive_mode_high};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe, zero otherwise
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // one cell per pin; decode is combinational so a write acts from the next edge
  genvar gi;
  generate
    for (gi = 0; gi < `EBIO_PINS; gi = gi + 1) begin : g_pin
      ebio_pin_cell u_cell (
        .dir(pin_direction[gi]),
        .mode({drive_mode_high[gi], drive_mode_low[gi]}),
        .level(pin_data[gi]),
        .seg_sel(segment_select[gi]),
        .seg_level(segment_level[gi]),
        .pad_out(pin_out[gi]),
        .pad_oe(pin_oe[gi]),
        .pull_up(pull_up_en[gi]),
        .pull_down(pull_down_en[gi])
      );
    end
  endgenerate

endmodule // ebio_port

// file: bench/ebio_pads.sv
module ebio_pads (
  input wire logic core_clk,
  input wire logic [7:0] pin_out, pin_oe, pull_up_en, pull_down_en,
  output logic [7:0] pin_in = 8'h00
);
  timeunit 1ns / 100ps;
  // pads seen through one flop; an unheld pad flips so a stale level cannot pass
  always @(posedge core_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] <= pin_out[i];
      else if (pull_up_en[i] | pull_down_en[i]) pin_in[i] <= pull_up_en[i];
      else pin_in[i] <= ~pin_in[i];
    end
  end
endmodule // ebio_pads

// file: bench/ebio_port_monitor.sv
module ebio_port_monitor (
  input wire logic core_clk, rst, bus_wr, bus_rd, bus_word,
  input wire logic [15:0] bus_addr, bus_wdata, bus_rdata,
  input wire logic [7:0] pin_oe, pull_up_en, pull_down_en, segment_select
);
  timeunit 1ns / 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // pulls anywhere, drive on pins the port keeps, and an all-zero mode word
  wire [7:0] pul = pull_up_en | pull_down_en;
  wire [7:0] own = pin_oe & ~segment_select;
  wire wzero = bus_wr & bus_word & (bus_addr == 16'hF272) & (bus_wdata == 16'h0000);
  property p_idle; !$past(bus_rd) |-> bus_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  property p_byte; $past(bus_rd & ~bus_word) |-> bus_rdata[15:8] == 8'h00; endproperty
  a_byte: assert property (p_byte) else $error("byte high");
  property p_gap; bus_rd && bus_addr[15:2] != 14'h3C9C |=> bus_rdata == 16'h0000; endproperty
  a_gap: assert property (p_gap) else $error("gap read");
  property p_seg; (segment_select & (~pin_oe | pul)) == 8'h00; endproperty
  a_seg: assert property (p_seg) else $error("segment pin");
  property p_pull; (pin_oe & pul) == 8'h00; endproperty
  a_pull: assert property (p_pull) else $error("pull on driven pin");
  property p_rst; $past(rst) |-> (own | pul) == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_in; bus_wr && !bus_word && bus_addr == 16'hF271 && bus_wdata[7:0] == 8'hFF
    |=> own == 8'h00; endproperty
  a_in: assert property (p_in) else $error("input driven");
  property p_off; wzero |=> (own | pul) == 8'h00; endproperty
  a_off: assert property (p_off) else $error("mode zero");
  c_rd: cover property (bus_rd ##1 bus_rdata[7:0] != 8'h00);
  c_pu: cover property (|pull_up_en);
  c_pd: cover property (|pull_down_en);
endmodule // ebio_port_monitor
bind ebio_port ebio_port_monitor ebio_port_monitor_inst (.*);

// file: bench/tb.sv
module tb;
  timeunit 1ns / 100ps;
  logic core_clk, rst, bus_wr, bus_rd, bus_word;
  logic [15:0] bus_addr, bus_wdata, q;
  logic [7:0] segment_select, segment_level, d, r, ml, mh, pi;
  wire [15:0] bus_rdata;
  wire [7:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
  integer seed = 32'hA971722F;
  integer err_count = 0;
  integer checked = 0;
  ebio_port ebio_port_inst (.*);
  ebio_pads ebio_pads_inst (.*);
  // core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // hang guard, about three times the expected run
  initial begin
    #60000;
    err_count++;
    results;
  end
  task results;
    $display("err_count %0d checked %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string n, input [15:0] e, s);
    checked++;
    if (e !== s) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // one strobe cycle; read data land in q, pad levels at the strobe edge in pi
  task bus(input [15:0] a, v, input w, wr);
    @(posedge core_clk);
    {bus_addr, bus_wdata, bus_word} <= {a, v, w};
    if (wr) bus_wr <= 1'b1;
    else bus_rd <= 1'b1;
    #1 pi = pin_in;
    @(posedge core_clk);
    {bus_wr, bus_rd} <= 2'b00;
    @(negedge core_clk);
    q = bus_rdata;
  endtask
  // oe, driven level, pull-up, pull-down expected on pin i
  function automatic [3:0] pexp(input int i);
    if (segment_select[i]) return {1'b1, segment_level[i], 2'b00};
    if (r[i]) return {2'b00, mh[i] & ~ml[i], ml[i] & ~mh[i]};
    return {ml[i] & mh[i] | (ml[i] ^ mh[i]) & (ml[i] ~^ d[i]), ml[i] & d[i], 2'b00};
  endfunction
  task pins;
    logic [3:0] g;
    for (int i = 0; i < 8; i++) begin
      g = {pin_oe[i], pin_oe[i] & pin_out[i], pull_up_en[i], pull_down_en[i]};
      chk("pin", 16'(pexp(i)), 16'(g));
    end
  endtask
  // reset values, a gap address, then random configurations with readback
  initial begin
    {rst, bus_wr, bus_rd, bus_word, bus_addr, bus_wdata} = {1'b1, 35'h0};
    {segment_select, segment_level, d, r, ml, mh} = 48'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      bus(16'hF270 + 16'(a), 16'h0000, 1'b0, 1'b0);
      chk("reset", 16'h0000, q);
    end
    bus(16'hF272, 16'h0000, 1'b1, 1'b1);
    bus(16'hF271, 16'h00FF, 1'b0, 1'b1);
    for (int k = 0; k < 40; k++) begin
      // mid-run reset must wipe whatever the earlier rounds left behind
      if (k == 20) begin
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
          bus(16'hF270 + 16'(a), 16'h0000, 1'b0, 1'b0);
          chk("rerun", 16'h0000, q);
        end
      end
      @(posedge core_clk);
      {segment_select, segment_level} <= 16'($random(seed));
      {d, r, ml, mh} = $random(seed);
      bus(16'hF270, {8'h00, d}, 1'b0, 1'b1);
      bus(16'hF271, {8'h00, r}, 1'b0, 1'b1);
      bus(16'hF272, k[0] ? {mh, ml} : {8'h00, ml}, k[0], 1'b1);
      if (!k[0]) bus(16'hF273, {8'h00, mh}, 1'b0, 1'b1);
      bus(16'hF271, {r, ~r}, 1'b1, 1'b1);
      pins;
      bus(16'hF270, 16'h0000, 1'b0, 1'b0);
      chk("data", {8'h00, r & pi | ~r & d}, q);
      bus(16'hF271, 16'h0000, 1'b0, 1'b0);
      chk("dir", {8'h00, r}, q);
      bus(16'hF272, 16'h0000, 1'b1, 1'b0);
      chk("mode", {mh, ml}, q);
      bus(k[0] ? 16'hF273 : 16'hF272, 16'h0000, 1'b0, 1'b0);
      chk("mode byte", {8'h00, k[0] ? mh : ml}, q);
    end
    results;
  end
endmodule // tb
